// *** verilog/watchdog_timer_control.sv ***
`include "watchdog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
// A smaller divider only shortens the oscillator period, as in a bench.
module watchdog_timer_control #(
  parameter int unsigned OSC_DIV = `WD_OSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire watchdog_pkg::wd_sys_t sys,
  output logic irq_req,
  output logic system_reset
);
  typedef struct packed {
    watchdog_pkg::wd_ctrl_t ctrl;
    logic [2:0] chg_cnt;
    logic [31:0] prdata;
    logic pslverr;
    logic irq_req;
    logic system_reset;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic tick;
  logic timeout;
  logic restart;
  logic run;
  logic wr;
  logic rd;
  logic [7:0] ctrl_rd;
  watchdog_pkg::wd_mode_t mode;
  watchdog_pkg::wd_ctrl_t w;
  watchdog_pkg::wd_ctrl_t c;

  osc_tick_gen #(.OSC_DIV(OSC_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  wd_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .tick(tick),
    .restart(restart),
    .ps(s_r.ctrl.ps),
    .timeout(timeout)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign restart = wr && paddr == `WD_CMD_OFFSET
    && pwdata[`WD_CMD_RESTART_BIT];
  assign run = mode != watchdog_pkg::MODE_STOPPED;

  always_comb begin
    c = s_r.ctrl;
    // The register keeps the upper prescale bit apart from the lower three.
    ctrl_rd = {c.flag, c.irq_en, c.ps[3], c.chg_en, c.rst_en, c.ps[2:0]};
    // [RULE_07] Clock monitor override
    if (sys.clock_monitor) begin
      mode = watchdog_pkg::MODE_RESET;
    // [RULE_08] Fuse gives reset-only
    end else if (sys.always_on_fuse) begin
      mode = watchdog_pkg::MODE_RESET;
    end else begin
      unique case ({c.rst_en, c.irq_en})
        2'b00: mode = watchdog_pkg::MODE_STOPPED;
        // [RULE_04] Interrupt-only mode
        2'b01: mode = watchdog_pkg::MODE_IRQ;
        2'b10: mode = watchdog_pkg::MODE_RESET;
        2'b11: mode = watchdog_pkg::MODE_IRQ_RESET;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    w.flag = pwdata[`WD_BIT_FLAG];
    w.irq_en = pwdata[`WD_BIT_IRQ_EN];
    w.chg_en = pwdata[`WD_BIT_CHG_EN];
    w.rst_en = pwdata[`WD_BIT_RST_EN];
    w.ps = {pwdata[`WD_BIT_PS3], pwdata[2:0]};
    s_nxt.system_reset = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (rd) begin
      unique case (paddr)
        `WD_CTRL_OFFSET: s_nxt.prdata = {24'h000000, ctrl_rd};
        `WD_CMD_OFFSET: s_nxt.prdata = 32'h00000000;
        default: begin
          s_nxt.prdata = 32'h00000000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      s_nxt.pslverr = paddr != `WD_CTRL_OFFSET && paddr != `WD_CMD_OFFSET;
    end
    // [RULE_09] Change window countdown
    if (s_r.chg_cnt != 3'h0) begin
      s_nxt.chg_cnt = s_r.chg_cnt - 3'h1;
      if (s_r.chg_cnt == 3'h1) begin
        s_nxt.ctrl.chg_en = 1'b0;
      end
    end
    if (wr && paddr == `WD_CTRL_OFFSET) begin
      s_nxt.ctrl.irq_en = w.irq_en;
      // [RULE_02] Write one clears flag
      if (w.flag) begin
        s_nxt.ctrl.flag = 1'b0;
      end
      // [RULE_10] Protected fields
      if (s_r.ctrl.chg_en) begin
        s_nxt.ctrl.rst_en = w.rst_en;
        s_nxt.ctrl.ps = w.ps;
      end else if (w.rst_en) begin
        s_nxt.ctrl.rst_en = 1'b1;
      end
      if (w.chg_en && w.rst_en) begin
        s_nxt.ctrl.chg_en = 1'b1;
        s_nxt.chg_cnt = `WD_CHG_WINDOW;
      end else if (!w.chg_en) begin
        s_nxt.ctrl.chg_en = 1'b0;
        s_nxt.chg_cnt = 3'h0;
      end
    end
    // [RULE_05] Vector clears enable and flag
    if (wr && paddr == `WD_CMD_OFFSET && pwdata[`WD_CMD_VECTOR_BIT]) begin
      s_nxt.ctrl.flag = 1'b0;
      if (mode == watchdog_pkg::MODE_IRQ_RESET) begin
        s_nxt.ctrl.irq_en = 1'b0;
      end
    end
    if (timeout) begin
      unique case (mode)
        // [RULE_01] Timeout sets flag
        watchdog_pkg::MODE_IRQ: s_nxt.ctrl.flag = 1'b1;
        watchdog_pkg::MODE_IRQ_RESET: begin
          // [RULE_06] Unserviced flag resets
          if (s_r.ctrl.flag) begin
            s_nxt.system_reset = 1'b1;
          end else begin
            s_nxt.ctrl.flag = 1'b1;
          end
        end
        watchdog_pkg::MODE_RESET: s_nxt.system_reset = 1'b1;
        watchdog_pkg::MODE_STOPPED: s_nxt.system_reset = 1'b0;
      endcase
    end
    // [RULE_11] Reset flag holds enable
    // [RULE_14] Stays enabled after reset
    if (sys.dog_reset_source_flag) begin
      s_nxt.ctrl.rst_en = 1'b1;
    end
    // [RULE_18] Fuse locks enables
    if (sys.always_on_fuse) begin
      s_nxt.ctrl.rst_en = 1'b1;
      s_nxt.ctrl.irq_en = 1'b0;
    end
    // [RULE_07] Monitor disables interrupt
    if (sys.clock_monitor) begin
      s_nxt.ctrl.irq_en = 1'b0;
    end
    // [RULE_03] Interrupt request gating
    s_nxt.irq_req = s_nxt.ctrl.flag && s_nxt.ctrl.irq_en
      && sys.global_irq_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = s_r.pslverr;
  assign irq_req = s_r.irq_req;
  assign system_reset = s_r.system_reset;
endmodule : watchdog_timer_control
`default_nettype wire

// *** verilog/watchdog_defines.svh ***
// Operation
// [RULE_01] Timeout with interrupt behaviour sets the timeout flag, bit 7.
// [RULE_02] Flag clears when the vector runs or software writes one to it.
// [RULE_03] Interrupt request needs flag, interrupt enable and global enable.
// [RULE_04] Interrupt enable without reset enable gives interrupt mode only.
// [RULE_05] Combined mode: vector execution clears interrupt enable and flag.
// [RULE_06] Combined mode: unserviced flag at next timeout gives system reset.
// [RULE_07] Clock monitoring forces reset behaviour and disables interrupts.
// [RULE_08] All enables zero means stopped; fuse set means reset-only.
// [RULE_09] Change enable clears itself four clock cycles after being set.
// [RULE_10] Clearing reset enable or prescaler changes need change enable.
// [RULE_11] Reset source flag set holds the reset enable at one.
// [RULE_12] Code N selects 2048 << N cycles; codes 10 to 15 reserved.
// [RULE_13] Software restarts the counter before changing the prescaler.
// [RULE_14] Reset enable stays on through a watchdog reset via the flag.
// [RULE_15] Init software clears the reset source flag then reset enable.
// [RULE_16] Software re-sets interrupt enable after each interrupt, not in it.
// [RULE_17] Protected change: set change and reset enable, then write values.
// [RULE_18] Fuse locks reset enable at one, interrupt enable at zero.
// [RULE_19] Counter counts cycles of a separate slow oscillator tick.
// [RULE_20] Restart instruction restarts the counter before the timeout.
// [RULE_21] After an interrupt-only timeout the counter restarts from zero.
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH
`define WD_CTRL_OFFSET 12'h000
`define WD_CMD_OFFSET 12'h004
`define WD_CMD_RESTART_BIT 0
`define WD_CMD_VECTOR_BIT 1
`define WD_BIT_FLAG 7
`define WD_BIT_IRQ_EN 6
`define WD_BIT_PS3 5
`define WD_BIT_CHG_EN 4
`define WD_BIT_RST_EN 3
`define WD_CHG_WINDOW 3'h4
`define WD_PS_MAX 4'h9
`define WD_BASE_SHIFT 11
`define WD_CNT_W 21
`define WD_OSC_HZ 128000
`define WD_CLK_HZ 100000000
`define WD_OSC_DIV (`WD_CLK_HZ / `WD_OSC_HZ)
`endif

// *** verilog/watchdog_pkg.sv ***
package watchdog_pkg;
  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_RESET = 2'b10,
    MODE_IRQ_RESET = 2'b11
  } wd_mode_t;
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic chg_en;
    logic rst_en;
    logic [3:0] ps;
  } wd_ctrl_t;
  typedef struct packed {
    logic global_irq_en;
    logic clock_monitor;
    logic always_on_fuse;
    logic dog_reset_source_flag;
  } wd_sys_t;
endpackage : watchdog_pkg

// *** verilog/osc_tick_gen.sv ***
`include "watchdog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
// Divides pclk into a one-cycle tick at the slow oscillator rate.
module osc_tick_gen #(
  parameter int unsigned OSC_DIV = `WD_OSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == 10'(OSC_DIV - 1)) begin
      s_nxt.cnt = 10'h000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 10'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tick = s_r.tick;
endmodule : osc_tick_gen
`default_nettype wire

// *** verilog/wd_counter.sv ***
`include "watchdog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
// Oscillator-cycle counter with a selectable timeout length.
module wd_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic restart,
  input wire logic [3:0] ps,
  output logic timeout
);
  typedef struct packed {
    logic [`WD_CNT_W-1:0] cnt;
    logic timeout;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic [`WD_CNT_W-1:0] limit;
  logic [3:0] ps_eff;
  always_comb begin
    // [RULE_12] Timeout length select
    ps_eff = (ps > `WD_PS_MAX) ? `WD_PS_MAX : ps;
    limit = `WD_CNT_W'(1) << (`WD_BASE_SHIFT + 32'(ps_eff));
    s_nxt = s_r;
    s_nxt.timeout = 1'b0;
    // [RULE_20] Software restart
    if (restart || !run) begin
      s_nxt.cnt = '0;
    // [RULE_19] Slow oscillator count
    end else if (tick) begin
      if (s_r.cnt >= limit - `WD_CNT_W'(1)) begin
        // [RULE_21] Restart after timeout
        s_nxt.cnt = '0;
        s_nxt.timeout = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + `WD_CNT_W'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign timeout = s_r.timeout;
endmodule : wd_counter
`default_nettype wire

// *** bench/watchdog_timer_control_chk.sv ***
`include "watchdog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_control_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire watchdog_pkg::wd_sys_t sys,
  input wire logic irq_req,
  input wire logic system_reset
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_ctrl;
    psel && penable && !pwrite && paddr == `WD_CTRL_OFFSET;
  endsequence
  sequence rd_cmd;
    psel && penable && !pwrite && paddr == `WD_CMD_OFFSET;
  endsequence
  sequence acc_unmapped;
    psel && penable && paddr != `WD_CTRL_OFFSET && paddr != `WD_CMD_OFFSET;
  endsequence
  a_irq_needs_global: assert property (
    irq_req |-> $past(sys.global_irq_en)) else $error("irq without enable");
  a_fuse_no_irq: assert property (
    sys.always_on_fuse [*3] |-> !irq_req) else $error("irq under fuse");
  a_clkmon_no_irq: assert property (
    sys.clock_monitor [*3] |-> !irq_req) else $error("irq under monitor");
  a_rflag_holds_rst: assert property (
    sys.dog_reset_source_flag [*4] ##0 rd_ctrl |-> prdata[`WD_BIT_RST_EN])
    else $error("reset enable not held");
  a_fuse_lock_bits: assert property (
    sys.always_on_fuse [*4] ##0 rd_ctrl |-> prdata[3] && !prdata[6])
    else $error("fuse lock lost");
  a_unmapped_err: assert property (
    acc_unmapped |-> pslverr) else $error("no error on unmapped");
  a_cmd_reads_zero: assert property (
    rd_cmd |-> prdata == 32'h0 && !pslverr) else $error("command read");
  a_reset_one_pulse: assert property (
    system_reset |=> !system_reset) else $error("reset pulse too long");
endmodule : watchdog_timer_control_chk
`default_nettype wire

// *** bench/testbench.sv ***
`include "watchdog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic irq_req, system_reset, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [7:0] cur;
  logic [1:0] ev;
  watchdog_pkg::wd_sys_t sys;
  int err_total, checked, n;
  localparam logic [11:0] C = `WD_CTRL_OFFSET;
  localparam logic [11:0] K = `WD_CMD_OFFSET;
  // One tick per clock brings the shortest timeout down to 2048 cycles.
  watchdog_timer_control #(.OSC_DIV(1)) watchdog_timer_control_i (
    .pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys(sys), .irq_req(irq_req),
    .system_reset(system_reset));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask : rd_chk
  // Waits until an output selected by m is high; ev holds both outputs.
  task automatic wait_evt(input logic [1:0] m, output int cnt,
                          output logic [1:0] seen);
    cnt = 0;
    seen = 2'b00;
    while ((seen & m) == 2'b00 && cnt < 3000) begin
      @(posedge pclk);
      cnt++;
      seen = {system_reset, irq_req};
    end
  endtask : wait_evt
  task automatic prot(input logic [7:0] d);
    wr(K, 8'h01);
    wr(C, cur | 8'h18);
    wr(C, d);
    cur = d;
  endtask : prot
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The run needs about eleven thousand cycles; thirty thousand is a hang.
  initial begin
    #300000;
    err_total++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sys = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(C, 32'h0);
    wr(C, 8'h08);
    rd_chk(C, 32'h08);
    wr(C, 8'h00);
    wr(C, 8'h0d);
    rd_chk(C, 32'h08);
    $display("test refused writes done");
    cur = 8'h08;
    for (int c = 0; c < 10; c++) begin
      prot({2'b00, c[3], 2'b00, c[2:0]});
      rd_chk(C, {24'h0, cur});
    end
    $display("test prescale codes done");
    wr(C, cur | 8'h18);
    rd_chk(C, 32'h39);
    repeat (5) @(posedge pclk);
    wr(C, 8'h00);
    rd_chk(C, 32'h29);
    cur = 8'h29;
    prot(8'h00);
    rd_chk(C, 32'h00);
    $display("test change window done");
    wr(C, 8'h40);
    wr(K, 8'h02);
    rd_chk(C, 32'h40);
    sys.global_irq_en <= 1'b1;
    wr(C, 8'hc8);
    chk({31'h0, irq_req}, 32'h0);
    wr(K, 8'h02);
    rd_chk(C, 32'h08);
    wr(K, 8'h01);
    rd_chk(K, 32'h0);
    xfer(1'b0, 12'h008, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    $display("test modes and commands done");
    sys.dog_reset_source_flag <= 1'b1;
    cur = 8'h08;
    prot(8'h00);
    rd_chk(C, 32'h08);
    sys.dog_reset_source_flag <= 1'b0;
    cur = 8'h08;
    prot(8'h00);
    rd_chk(C, 32'h00);
    sys.always_on_fuse <= 1'b1;
    wr(C, 8'h40);
    rd_chk(C, 32'h08);
    sys.always_on_fuse <= 1'b0;
    cur = 8'h08;
    prot(8'h00);
    sys.clock_monitor <= 1'b1;
    wr(C, 8'h40);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    $display("test overrides done");
    sys.clock_monitor <= 1'b0;
    wr(C, 8'h40);
    wr(K, 8'h01);
    wait_evt(2'b11, n, ev);
    chk({30'h0, ev}, 32'h1);
    chk(32'(n inside {[2048:2055]}), 32'h1);
    rd_chk(C, 32'hc0);
    wr(C, 8'hc0);
    rd_chk(C, 32'h40);
    chk({31'h0, irq_req}, 32'h0);
    wait_evt(2'b01, n, ev);
    chk(32'(n < 2048), 32'h1);
    wr(C, 8'hc8);
    wr(K, 8'h01);
    wait_evt(2'b11, n, ev);
    chk({30'h0, ev}, 32'h1);
    wr(K, 8'h02);
    rd_chk(C, 32'h08);
    wr(C, 8'h48);
    wait_evt(2'b11, n, ev);
    chk({30'h0, ev}, 32'h1);
    wait_evt(2'b10, n, ev);
    chk({30'h0, ev}, 32'h3);
    $display("test timeouts done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(C, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule : testbench
bind watchdog_timer_control watchdog_timer_control_chk chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys(sys), .irq_req(irq_req),
  .system_reset(system_reset));
`default_nettype wire
